// ### hdl/dop_port_cmd.sv
// Purpose: command interpreter for a four-port 8-bit digital output module
// Assumes: single clock, commands issued through AXI4-Lite registers
// Notes:   readback text is popped one character per read of the text register
// Operation
// - direction set: 1 output, 0 input
// - direction query returns bit per listed channel
// - byte accepts channels 11-14 only, else -221
// - byte sets independent 8-bit channel pattern
// - values parsed decimal or #B, #H, #Q
// - readback header #B, #H, #O or #Q
// - word accepts channels 11 and 13 only
// - word maps low byte then high byte
// - word needs both pair channels output
// - double-word accepts channel 11 only
// - double-word maps bytes onto channels 11-14
// - double-word needs all four channels output
// - short binary strings are right-aligned
// - selectable queryable readback format
// - length zero gives no leading zeros
// - length 1-32 fixes digits, keeps low ones
// - format query gives format and length
// - queries return currently set pattern
// - pattern access on input port gives -221
// - preset makes all channels inputs
// - default pattern is all ones
// - formats decimal, binary, hex, octal
`timescale 1ns/10ps
module dop_port_cmd (
	// clock and reset
	input  wire logic                  ref_clk_in,
	input  wire logic                  sys_rst_in,
	// register bus
	input  wire dop_pkg::dop_axi_req_t axi_req_in,
	output      dop_pkg::dop_axi_rsp_t axi_rsp_out,
	// output lines
	output      logic [31:0]           dout_out,
	output      logic [3:0]            dout_oe_n_out
);
	import dop_pkg::*;

	typedef struct packed {
		dop_axi_rsp_t rsp;
		logic         awh;
		logic         wh;
		logic [7:0]   awa;
		logic [31:0]  wd;
		logic [3:0]   ws;
		dop_st_t      st;
		dop_op_t      op;
		logic [1:0]   cnt;
		logic [31:0]  clist;
		logic [31:0]  pval;
		dop_fmt_t     prad;
		logic         phash;
		logic         perr;
		dop_fmt_t     fmt;
		logic [5:0]   flen;
		logic [3:0]   dir;
		logic [31:0]  pat;
		logic [3:0]   oen;
		logic         err;
		logic [31:0]  res;
		logic [31:0]  fv;
		logic [4:0]   rem;
		logic [4:0]   dcnt;
		logic [5:0]   nd;
		logic [127:0] dbuf;
		logic         hv;
		logic [7:0]   hdr;
		logic [5:0]   tpos;
	} dop_state_t;

	dop_state_t  q;
	dop_state_t  d;
	logic        wr_go;
	logic        hit;
	logic        bad;
	logic        dvok;
	logic        done_dig;
	logic        tval;
	logic [7:0]  c;
	logic [7:0]  cu;
	logic [7:0]  ch;
	logic [7:0]  tch;
	logic [1:0]  ix;
	logic [3:0]  dv;
	logic [3:0]  dig;
	logic [3:0]  t_dir;
	logic [4:0]  r;
	logic [4:0]  di;
	logic [5:0]  hl;
	logic [5:0]  nd1;
	logic [31:0] wm;
	logic [31:0] rdv;
	logic [31:0] t_pat;
	logic [31:0] t_fv;
	logic [31:0] t_res;
	logic [31:0] nfv;
	logic [31:0] f;

	// byte-lane merge for partial writes
	function automatic logic [31:0] dop_merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (o & ~m) | (n & m);
	endfunction

	// next-state logic: bus slave, parser, command engine, formatter
	always_comb begin
		d = q;
		wr_go = 1'b0;
		bad = 1'b0;
		dvok = 1'b0;
		done_dig = 1'b0;
		c = 8'h00;
		cu = 8'h00;
		ch = 8'h00;
		ix = 2'h0;
		dv = 4'h0;
		dig = 4'h0;
		r = 5'h00;
		f = 32'h0;
		nfv = 32'h0;
		nd1 = 6'h0;
		t_dir = q.dir;
		t_pat = q.pat;
		t_fv = 32'h0;
		t_res = 32'h0;
		wm = dop_merge(32'h0, q.wd, q.ws);
		hit = (q.awa <= ADDR_STAT) && (q.awa[1:0] == 2'h0);

		// text view: header first, then digits most significant first
		hl = q.hv ? 6'h2 : 6'h0;
		tval = (q.st == ST_IDLE) && (q.tpos < 6'(q.nd + hl));
		di = 5'(q.nd - 6'h1 - (q.tpos - hl));
		dig = q.dbuf[{di, 2'b00} +: 4];
		if (q.hv && q.tpos < 6'h2) begin
			tch = (q.tpos == 6'h0) ? CHR_HASH : q.hdr;
		end else if (dig < 4'ha) begin
			tch = CHR_0 + {4'h0, dig};
		end else begin
			tch = CHR_A + {4'h0, dig} - 8'h0a;
		end
		dig = 4'h0;

		// address and data channels, taken in either order
		if (q.rsp.awready && axi_req_in.awvalid) begin
			d.awh = 1'b1;
			d.awa = axi_req_in.awaddr;
		end
		if (q.rsp.wready && axi_req_in.wvalid) begin
			d.wh = 1'b1;
			d.wd = axi_req_in.wdata;
			d.ws = axi_req_in.wstrb;
		end
		if (q.rsp.bvalid && axi_req_in.bready) begin
			d.rsp.bvalid = 1'b0;
		end
		wr_go = q.awh && q.wh && !q.rsp.bvalid;

		// register write effects
		if (wr_go) begin
			d.awh = 1'b0;
			d.wh = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp = hit ? RESP_OKAY : RESP_SLVERR;
			case (q.awa)
				ADDR_CMD: begin
					// commands arriving while busy are dropped
					if (q.ws[0] && q.st == ST_IDLE) begin
						d.op = dop_op_t'(q.wd[3:0]);
						d.cnt = q.wd[CMD_CNT_LSB +: 2];
						d.st = ST_EXEC;
					end
				end
				ADDR_CLIST: d.clist = dop_merge(q.clist, q.wd, q.ws);
				ADDR_PCHAR: begin
					c = q.wd[7:0];
					cu = c & CHR_UPPER;
					if (q.ws[1] && q.wd[PCHAR_CLR_BIT]) begin
						d.pval = 32'h0;
						d.prad = FMT_ASC;
						d.phash = 1'b0;
						d.perr = 1'b0;
					end else if (q.ws[0]) begin
						if (c == CHR_HASH) begin
							d.phash = 1'b1;
						end else if (q.phash) begin
							d.phash = 1'b0;
							case (cu)
								CHR_B: d.prad = FMT_BIN;
								CHR_H: d.prad = FMT_HEX;
								CHR_Q: d.prad = FMT_OCT;
								default: d.perr = 1'b1;
							endcase
						end else begin
							if (c >= CHR_0 && c <= CHR_9) begin
								dv = 4'(c - CHR_0);
								dvok = 1'b1;
							end else if (cu >= CHR_A && cu <= CHR_F) begin
								dv = 4'(cu - CHR_A + 8'h0a);
								dvok = 1'b1;
							end
							// digits shift in from the right
							case (q.prad)
								FMT_BIN: begin
									dvok = dvok && (dv < 4'h2);
									d.pval = (q.pval << 1) | {28'h0, dv};
								end
								FMT_OCT: begin
									dvok = dvok && (dv < 4'h8);
									d.pval = (q.pval << 3) | {28'h0, dv};
								end
								FMT_HEX: d.pval = (q.pval << 4) | {28'h0, dv};
								default: begin
									dvok = dvok && (dv < 4'ha);
									d.pval = (q.pval << 3) + (q.pval << 1) + {28'h0, dv};
								end
							endcase
							if (!dvok) begin
								d.pval = q.pval;
								d.perr = 1'b1;
							end
						end
					end
				end
				ADDR_FMT: begin
					// format held until rewritten, frozen while busy
					if (q.st == ST_IDLE) begin
						wm = dop_merge({18'h0, q.flen, 6'h0, q.fmt}, q.wd, q.ws);
						if (wm[FMT_LEN_LSB +: 6] > LEN_MAX) begin
							d.err = 1'b1;
						end else begin
							d.fmt = dop_fmt_t'(wm[1:0]);
							d.flen = wm[FMT_LEN_LSB +: 6];
						end
					end
				end
				ADDR_ERR: d.err = 1'b0;
				default: ;
			endcase
		end

		// read channel; a text read pops one character
		if (q.rsp.rvalid && axi_req_in.rready) begin
			d.rsp.rvalid = 1'b0;
		end
		if (q.rsp.arready && axi_req_in.arvalid) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rresp = RESP_OKAY;
			case (axi_req_in.araddr)
				ADDR_CMD:   rdv = {26'h0, q.cnt, q.op};
				ADDR_CLIST: rdv = q.clist;
				ADDR_PCHAR: rdv = {29'h0, q.perr, q.phash, 1'b0};
				ADDR_PVAL:  rdv = q.pval;
				// format and length side by side
				ADDR_FMT:   rdv = {18'h0, q.flen, 6'h0, q.fmt};
				ADDR_DIR:   rdv = {28'h0, q.dir};
				ADDR_RES:   rdv = q.res;
				ADDR_TEXT:  rdv = {23'h0, tval, tval ? tch : 8'h00};
				ADDR_ERR:   rdv = q.err ? ERR_CONFLICT : 32'h0;
				ADDR_STAT:  rdv = {28'h0, tval, q.perr, q.err, q.st != ST_IDLE};
				default: begin
					rdv = 32'h0;
					d.rsp.rresp = RESP_SLVERR;
				end
			endcase
			d.rsp.rdata = rdv;
			if (axi_req_in.araddr == ADDR_TEXT && tval) begin
				d.tpos = q.tpos + 6'h1;
			end
		end else begin
			rdv = 32'h0;
		end

		case (q.st)
			ST_IDLE: ;
			ST_EXEC: begin
				// whole list checked before anything changes
				for (int i = 0; i < 4; i++) begin
					if (i <= int'(q.cnt)) begin
						ch = q.clist[8 * i +: 8];
						ix = 2'(ch - CH_FIRST);
						case (q.op)
							OP_DIR_SET, OP_DIR_QRY: begin
								bad = bad || ch < CH_FIRST || ch > CH_LAST;
								// 1 output, 0 input
								// queries must leave the directions as they are
								if (q.op == OP_DIR_SET) t_dir[ix] = q.pval[0];
								t_res[i] = q.dir[ix];
							end
							OP_BYTE_SET, OP_BYTE_QRY: begin
								bad = bad || ch < CH_FIRST || ch > CH_LAST;
								bad = bad || !q.dir[ix];
								if (q.op == OP_BYTE_SET) t_pat[{ix, 3'b000} +: 8] = q.pval[7:0];
								if (i == 0) t_fv = {24'h0, q.pat[{ix, 3'b000} +: 8]};
							end
							OP_WORD_SET, OP_WORD_QRY: begin
								bad = bad || !(ch == CH_FIRST || ch == CH_PAIR_HI);
								bad = bad || !q.dir[ix] || !q.dir[ix + 2'h1];
								// low byte on first channel
								// pair base stays inside the pattern for any index
								if (q.op == OP_WORD_SET) t_pat[{ix[1], 4'h0} +: 16] = q.pval[15:0];
								if (i == 0) t_fv = {16'h0, q.pat[{ix[1], 4'h0} +: 16]};
							end
							OP_DWORD_SET, OP_DWORD_QRY: begin
								bad = bad || ch != CH_FIRST;
								bad = bad || q.dir != 4'hf;
								if (q.op == OP_DWORD_SET) t_pat = q.pval;
								if (i == 0) t_fv = q.pat;
							end
							OP_PRESET: ;
							default: bad = 1'b1;
						endcase
					end
				end
				// values too wide for the target are refused, not cut
				case (q.op)
					OP_DIR_SET:  bad = bad || q.pval > 32'h1 || q.perr;
					OP_BYTE_SET: bad = bad || q.pval[31:8] != 24'h0 || q.perr;
					OP_WORD_SET: bad = bad || q.pval[31:16] != 16'h0 || q.perr;
					OP_DWORD_SET: bad = bad || q.perr;
					default: ;
				endcase
				d.st = ST_IDLE;
				d.nd = 6'h0;
				d.hv = 1'b0;
				d.tpos = 6'h0;
				if (q.op == OP_PRESET) begin
					d.dir = DIR_RESET;
				end else if (bad) begin
					d.err = 1'b1;
				end else begin
					d.dir = t_dir;
					d.pat = t_pat;
					d.res = t_res;
					if (q.op == OP_BYTE_QRY || q.op == OP_WORD_QRY || q.op == OP_DWORD_QRY) begin
						// readback of the pattern now set
						d.res = t_fv;
						d.fv = t_fv;
						d.rem = 5'h00;
						d.dcnt = 5'h00;
						d.st = ST_FMT;
						// radix header, octal letter by width
						d.hv = q.fmt != FMT_ASC;
						case (q.fmt)
							FMT_BIN: d.hdr = CHR_B;
							FMT_HEX: d.hdr = CHR_H;
							default: d.hdr = (q.op == OP_BYTE_QRY) ? CHR_O : CHR_Q;
						endcase
					end
				end
			end
			ST_FMT: begin
				// one digit per step for power-of-two radices
				case (q.fmt)
					FMT_BIN: begin
						dig = {3'h0, q.fv[0]};
						nfv = q.fv >> 1;
						done_dig = 1'b1;
					end
					FMT_HEX: begin
						dig = q.fv[3:0];
						nfv = q.fv >> 4;
						done_dig = 1'b1;
					end
					FMT_OCT: begin
						dig = {1'b0, q.fv[2:0]};
						nfv = q.fv >> 3;
						done_dig = 1'b1;
					end
					default: begin
						// decimal: restoring divide by ten, one bit a cycle
						r = {q.rem[3:0], q.fv[31]};
						f = {q.fv[30:0], 1'b0};
						if (r >= 5'h0a) begin
							r = r - 5'h0a;
							f[0] = 1'b1;
						end
						d.rem = r;
						d.fv = f;
						d.dcnt = q.dcnt + 5'h01;
						if (q.dcnt == 5'h1f) begin
							dig = r[3:0];
							nfv = f;
							done_dig = 1'b1;
							d.rem = 5'h00;
						end
					end
				endcase
				if (done_dig) begin
					d.dbuf[{q.nd[4:0], 2'b00} +: 4] = dig;
					nd1 = q.nd + 6'h1;
					d.nd = nd1;
					d.fv = nfv;
					// stop once the value is used up
					// fixed count keeps the low digits
					if ((q.flen == 6'h0) ? (nfv == 32'h0) : (nd1 == q.flen)) begin
						d.st = ST_IDLE;
					end
					if (nd1 == LEN_MAX) d.st = ST_IDLE;
				end
			end
			default: d.st = ST_IDLE;
		endcase

		d.rsp.awready = !d.awh;
		d.rsp.wready = !d.wh;
		d.rsp.arready = !d.rsp.rvalid;
		d.oen = ~d.dir;
	end

	// state register; patterns come up all ones, ports as inputs
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			q <= '0;
			q.pat <= PAT_RESET;
			q.oen <= 4'hf;
		end else begin
			q <= d;
		end
	end

	assign axi_rsp_out = q.rsp;
	assign dout_out = q.pat;
	assign dout_oe_n_out = q.oen;

	// checks on the command engine
	property p_byte_range;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(q.st == ST_EXEC && q.op == OP_BYTE_SET && q.cnt == 2'h0 &&
			(q.clist[7:0] < CH_FIRST || q.clist[7:0] > CH_LAST)) |=> q.err && $stable(q.pat);
	endproperty
	a_byte_range: assert property (p_byte_range) else $error("bad byte channel taken");

	property p_word_chan;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(q.st == ST_EXEC && (q.op == OP_WORD_SET || q.op == OP_WORD_QRY) &&
			q.clist[7:0] != CH_FIRST && q.clist[7:0] != CH_PAIR_HI) |=> q.err;
	endproperty
	a_word_chan: assert property (p_word_chan) else $error("bad word channel taken");

	property p_dword_chan;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(q.st == ST_EXEC && q.op == OP_DWORD_SET && q.clist[7:0] != CH_FIRST)
			|=> q.err && $stable(q.pat);
	endproperty
	a_dword_chan: assert property (p_dword_chan) else $error("bad dword channel taken");

	property p_word_dir;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(q.st == ST_EXEC && q.op == OP_WORD_SET &&
			((q.clist[7:0] == CH_FIRST && q.dir[1:0] != 2'h3) ||
			(q.clist[7:0] == CH_PAIR_HI && q.dir[3:2] != 2'h3))) |=> q.err && $stable(q.pat);
	endproperty
	a_word_dir: assert property (p_word_dir) else $error("word set on input pair");

	property p_dword_dir;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(q.st == ST_EXEC && q.op == OP_DWORD_SET && q.dir != 4'hf) |=> q.err ##0 $stable(q.pat);
	endproperty
	a_dword_dir: assert property (p_dword_dir) else $error("dword set on input port");

	property p_word_map;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(q.st == ST_EXEC && q.op == OP_WORD_SET && q.clist[7:0] == CH_FIRST && !bad)
			|=> dout_out[15:0] == $past(q.pval[15:0]) && dout_out[31:16] == $past(q.pat[31:16]);
	endproperty
	a_word_map: assert property (p_word_map) else $error("word pattern misplaced");

	property p_dword_map;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(q.st == ST_EXEC && q.op == OP_DWORD_SET && !bad) |=> dout_out == $past(q.pval);
	endproperty
	a_dword_map: assert property (p_dword_map) else $error("dword pattern misplaced");

	property p_preset;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(q.st == ST_EXEC && q.op == OP_PRESET) |=> q.dir == 4'h0 ##1 dout_oe_n_out == 4'hf;
	endproperty
	a_preset: assert property (p_preset) else $error("preset left an output");

	property p_oe_dir;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		dout_oe_n_out == ~q.dir;
	endproperty
	a_oe_dir: assert property (p_oe_dir) else $error("driver enable off direction");

	property p_default_pat;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		$fell(sys_rst_in) |-> dout_out == PAT_RESET && q.dir == DIR_RESET;
	endproperty
	a_default_pat: assert property (p_default_pat) else $error("reset pattern not ones");

	property p_fixed_len;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(q.st == ST_FMT && d.st == ST_IDLE && q.flen != 6'h0) |=> q.nd == $past(q.flen);
	endproperty
	a_fixed_len: assert property (p_fixed_len) else $error("digit count off length");

	property p_free_len;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(q.st == ST_FMT && d.st == ST_IDLE && q.flen == 6'h0) |=> q.fv == 32'h0 || q.nd == LEN_MAX;
	endproperty
	a_free_len: assert property (p_free_len) else $error("free length stopped early");
endmodule

// ### shared/dop_pkg.sv
// Purpose: shared constants and types for the digital output port command block
// Assumes: AXI4-Lite register access, 32-bit data, byte addressing
// Notes:   channel numbers are plain binary values (11 to 14)
package dop_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CMD   = 8'h00;
	localparam logic [7:0] ADDR_CLIST = 8'h04;
	localparam logic [7:0] ADDR_PCHAR = 8'h08;
	localparam logic [7:0] ADDR_PVAL  = 8'h0c;
	localparam logic [7:0] ADDR_FMT   = 8'h10;
	localparam logic [7:0] ADDR_DIR   = 8'h14;
	localparam logic [7:0] ADDR_RES   = 8'h18;
	localparam logic [7:0] ADDR_TEXT  = 8'h1c;
	localparam logic [7:0] ADDR_ERR   = 8'h20;
	localparam logic [7:0] ADDR_STAT  = 8'h24;
	// field positions
	localparam int unsigned CMD_CNT_LSB   = 4;
	localparam int unsigned PCHAR_CLR_BIT = 8;
	localparam int unsigned FMT_LEN_LSB   = 8;
	// channel numbers
	localparam logic [7:0] CH_FIRST   = 8'h0b;
	localparam logic [7:0] CH_LAST    = 8'h0e;
	localparam logic [7:0] CH_PAIR_HI = 8'h0d;
	// reset values and codes
	localparam logic [31:0] PAT_RESET    = 32'hffffffff;
	localparam logic [3:0]  DIR_RESET    = 4'h0;
	localparam logic [31:0] ERR_CONFLICT = 32'hffffff23;
	localparam logic [5:0]  LEN_MAX      = 6'h20;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	// ascii characters
	localparam logic [7:0] CHR_HASH = 8'h23;
	localparam logic [7:0] CHR_0    = 8'h30;
	localparam logic [7:0] CHR_9    = 8'h39;
	localparam logic [7:0] CHR_A    = 8'h41;
	localparam logic [7:0] CHR_F    = 8'h46;
	localparam logic [7:0] CHR_B    = 8'h42;
	localparam logic [7:0] CHR_H    = 8'h48;
	localparam logic [7:0] CHR_O    = 8'h4f;
	localparam logic [7:0] CHR_Q    = 8'h51;
	localparam logic [7:0] CHR_UPPER = 8'hdf;

	typedef enum logic [3:0] {
		OP_DIR_SET, OP_DIR_QRY, OP_BYTE_SET, OP_BYTE_QRY, OP_WORD_SET,
		OP_WORD_QRY, OP_DWORD_SET, OP_DWORD_QRY, OP_PRESET
	} dop_op_t;
	typedef enum logic [1:0] {FMT_ASC, FMT_BIN, FMT_HEX, FMT_OCT} dop_fmt_t;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FMT} dop_st_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} dop_axi_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} dop_axi_rsp_t;
endpackage

// ### verif/dop_line_load.sv
// Purpose: pin-side load seen by the four output ports
// Assumes: every released line has a pull-up
// Notes:   gives the level an outside observer reads
`timescale 1ns/10ps
module dop_line_load (
	// driver side
	input  wire logic [31:0] dout_in,
	input  wire logic [3:0]  oe_n_in,
	// pin levels
	output      logic [31:0] pin_out
);
	// released ports float up, so stale data never shows
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_out[8*i +: 8] = oe_n_in[i] ? 8'hff : dout_in[8*i +: 8];
		end
	end
endmodule

// ### verif/tb_dop_port_cmd.sv
// Purpose: self-checking bench for the output port command block
// Assumes: register access through AXI4-Lite tasks only
// Notes:   each command polls busy, then checks and clears the error word
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_dop_port_cmd;
	import dop_pkg::*;
	logic         ref_clk_in;
	logic         sys_rst_in;
	dop_axi_req_t req;
	dop_axi_rsp_t rsp;
	logic [31:0]  dout;
	logic [31:0]  pins;
	logic [31:0]  rv;
	logic [1:0]   rr;
	logic [1:0]   br;
	logic [3:0]   oe_n;
	logic [127:0] txt;
	int           n_errors;
	int           check_count;
	int           cyc = 0;
	string        vs[4] = '{"#B100101", "#H3a", "#q45", "58"};
	logic [7:0]   ev[4] = '{8'h25, 8'h3a, 8'h25, 8'h3a};
	logic [127:0] te[4] = '{"#B111010", "#H3A", "#O72", "58"};

	dop_port_cmd uut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .axi_req_in(req),
		.axi_rsp_out(rsp), .dout_out(dout), .dout_oe_n_out(oe_n));
	dop_line_load load (.dout_in(dout), .oe_n_in(oe_n), .pin_out(pins));

	// free-running clock
	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end

	task automatic final_report();
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// watchdog, well above the thousand or so cycles needed
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end

	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge ref_clk_in);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		forever begin
			@(posedge ref_clk_in);
			if (!aw_ok && rsp.awready === 1'b1) begin
				aw_ok = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (!w_ok && rsp.wready === 1'b1) begin
				w_ok = 1'b1;
				req.wvalid <= 1'b0;
			end
			if (rsp.bvalid === 1'b1) begin
				br = rsp.bresp;
				req.bready <= 1'b0;
				break;
			end
		end
	endtask

	// read: data and response taken at the rvalid edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk_in);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		forever begin
			@(posedge ref_clk_in);
			if (rsp.arready === 1'b1) begin
				req.arvalid <= 1'b0;
			end
			if (rsp.rvalid === 1'b1) begin
				d = rsp.rdata;
				r = rsp.rresp;
				req.rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(nm, ex, d)
	endtask

	// one command: list, value text, start, wait idle, error check
	task automatic go(input dop_op_t op, input logic [1:0] cnt, input logic [31:0] cl,
		input string s, input logic er);
		logic [31:0] d;
		logic [1:0]  r;
		wr(ADDR_CLIST, cl);
		wr(ADDR_PCHAR, 32'h00000100);
		for (int i = 0; i < s.len(); i++) begin
			wr(ADDR_PCHAR, {24'h000000, s[i]});
		end
		wr(ADDR_CMD, {26'h0, cnt, op});
		do rd(ADDR_STAT, d, r); while (d[0] !== 1'b0);
		rd(ADDR_ERR, d, r);
		`CHK("err", (er ? ERR_CONFLICT : 32'h00000000), d)
		wr(ADDR_ERR, 32'h00000000);
	endtask

	// drain readback text until the valid bit drops
	task automatic qtext(input logic [127:0] ex);
		logic [31:0] d;
		logic [1:0]  r;
		txt = '0;
		for (int i = 0; i < 36; i++) begin
			rd(ADDR_TEXT, d, r);
			if (d[8] !== 1'b1) break;
			txt = {txt[119:0], d[7:0]};
		end
		`CHK("text", ex, txt)
	endtask

	// main sequence
	initial begin
		req = '0;
		sys_rst_in = 1'b1;
		n_errors = 0;
		check_count = 0;
		repeat (6) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		@(posedge ref_clk_in);
		`CHK("pins", 32'hffffffff, pins)
		`CHK("oe_n", 4'hf, oe_n)
		rchk("dir", ADDR_DIR, 32'h00000000);
		rchk("fmt", ADDR_FMT, 32'h00000000);
		go(OP_BYTE_SET, 2'h0, 32'h0000000b, "5", 1'b1);
		go(OP_BYTE_QRY, 2'h0, 32'h0000000b, "", 1'b1);
		go(OP_DIR_SET, 2'h1, 32'h00000c0b, "1", 1'b0);
		`CHK("oe_n", 4'hc, oe_n)
		go(OP_DIR_QRY, 2'h3, 32'h0b0c0d0e, "", 1'b0);
		rchk("res", ADDR_RES, 32'h0000000c);
		go(OP_DIR_SET, 2'h0, 32'h0000000b, "2", 1'b1);
		// alternating values so a failed parse leaves a visible stale byte
		for (int i = 0; i < 4; i++) begin
			go(OP_BYTE_SET, 2'h0, 32'h0000000c, vs[i], 1'b0);
			`CHK("pins", {16'hffff, ev[i], 8'hff}, pins)
		end
		go(OP_BYTE_SET, 2'h0, 32'h0000000f, "1", 1'b1);
		go(OP_BYTE_SET, 2'h0, 32'h0000000a, "1", 1'b1);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_FMT, 32'((i + 1) % 4));
			go(OP_BYTE_QRY, 2'h0, 32'h0000000c, "", 1'b0);
			qtext(te[i]);
		end
		go(OP_WORD_SET, 2'h0, 32'h0000000b, "#B100000111", 1'b0);
		`CHK("pins", 32'hffff0107, pins)
		wr(ADDR_FMT, 32'h00000003);
		go(OP_WORD_QRY, 2'h0, 32'h0000000b, "", 1'b0);
		qtext("#Q407");
		go(OP_WORD_SET, 2'h0, 32'h0000000c, "1", 1'b1);
		go(OP_WORD_SET, 2'h0, 32'h0000000d, "1", 1'b1);
		go(OP_DWORD_SET, 2'h0, 32'h0000000b, "1", 1'b1);
		go(OP_DIR_SET, 2'h3, 32'h0b0c0d0e, "1", 1'b0);
		go(OP_DWORD_SET, 2'h0, 32'h0000000d, "1", 1'b1);
		go(OP_DWORD_SET, 2'h0, 32'h0000000b, "16777479", 1'b0);
		`CHK("dout", 32'h01000107, dout)
		wr(ADDR_FMT, 32'h00000202);
		`CHK("bresp", RESP_OKAY, br)
		go(OP_DWORD_QRY, 2'h0, 32'h0000000b, "", 1'b0);
		qtext("#H07");
		wr(ADDR_FMT, 32'h00000a02);
		go(OP_DWORD_QRY, 2'h0, 32'h0000000b, "", 1'b0);
		qtext("#H0001000107");
		rchk("fmt", ADDR_FMT, 32'h00000a02);
		// length above the top of the range is refused
		wr(ADDR_FMT, 32'h00002102);
		rchk("fmt", ADDR_FMT, 32'h00000a02);
		rchk("err", ADDR_ERR, ERR_CONFLICT);
		wr(ADDR_ERR, 32'h00000000);
		go(OP_PRESET, 2'h0, 32'h00000000, "", 1'b0);
		// undefined operation code is refused
		go(dop_op_t'(4'h9), 2'h0, 32'h0000000b, "", 1'b1);
		rchk("dir", ADDR_DIR, 32'h00000000);
		`CHK("oe_n", 4'hf, oe_n)
		rchk("fmt", ADDR_FMT, 32'h00000a02);
		// unmapped address answers with an error response
		wr(8'h28, 32'h00000000);
		`CHK("bresp", RESP_SLVERR, br)
		rd(8'h28, rv, rr);
		`CHK("rresp", RESP_SLVERR, rr)
		final_report();
	end
endmodule
